// *** hw/amv_core.v ***
// Purpose: Memory-access parameter checker, watchdog and MAC-verify engine
// Assumes: External SHA-256 engine takes one word per cycle
// Notes:   Registers over APB; one wait state on every access
//
// Chosen here: the address map and register access over APB.
`include "amv_map.vh"
`timescale 1ns/1ps
`default_nettype none
module amv_core #(
    parameter [24:0] WDOG_CYCLES = `AMV_WDOG_MS * `AMV_CLK_KHZ
) (
    // Clock and reset
    input  wire         core_clk,
    input  wire         rst,
    // APB slave
    input  wire         psel,
    input  wire         penable,
    input  wire         pwrite,
    input  wire [11:0]  paddr,
    input  wire [31:0]  pwdata,
    output reg  [31:0]  prdata,
    output reg          pready,
    output reg          pslverr,
    // Hash engine
    output reg  [31:0]  shaWord_r,
    output reg          shaValid_r,
    output reg          shaLast_r,
    input  wire [255:0] shaDigest,
    input  wire         shaDone
);
    localparam [2:0] P_SLEEP = 3'b001;
    localparam [2:0] P_AWAKE = 3'b010;
    localparam [2:0] P_IDLE  = 3'b100;
    localparam [5:0] C_IDLE = 6'b000001;
    localparam [5:0] C_STRM = 6'b000010;
    localparam [5:0] C_WDIG = 6'b000100;
    localparam [5:0] C_CMP  = 6'b001000;
    localparam [5:0] C_COPY = 6'b010000;
    localparam [5:0] C_CLR  = 6'b100000;
    localparam [1:0] S_RAM = 2'h0;
    localparam [1:0] S_SCR = 2'h1;
    localparam [1:0] S_TAIL = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    reg  [15:0]  cmd_r;
    reg  [15:0]  addr_r;
    reg  [5:0]   cfg_r;
    reg  [23:0]  serial_r;
    reg  [31:0]  otp0_r;
    reg  [31:0]  otp1_r;
    reg  [31:0]  ex0_r;
    reg  [31:0]  ex1_r;
    reg  [31:0]  ex2_r;
    reg  [7:0]   ex3_r;
    reg  [2:0]   pwr_r;
    reg  [5:0]   cst_r;
    reg  [24:0]  wdCnt_r;
    reg  [4:0]   wIdx_r;
    reg  [4:0]   pW_r;
    reg  [1:0]   pSel_r;
    reg          pV_r;
    reg  [3:0]   cIdx_r;
    reg  [4:0]   clrIdx_r;
    reg          miss_r;
    reg  [255:0] dig_r;
    reg  [7:0]   stat_r;
    reg          copied_r;
    reg          nflag_r;
    reg  [31:0]  scr_r [0:7];
    wire [255:0] scfgV;
    wire [31:0]  ramQ;
    reg  [4:0]   ramRd;
    reg  [31:0]  rdMux;
    reg          rdErr;
    reg  [7:0]   accCode;
    reg  [3:0]   accBlk;
    integer      i;

    wire [7:0] opc    = cmd_r[7:0];
    wire [7:0] p1     = cmd_r[15:8];
    wire       busy   = (cst_r != C_IDLE);
    wire       awake  = (pwr_r == P_AWAKE);
    wire       wrDone = psel & penable & pready & pwrite;
    wire       ctlWr  = wrDone & (paddr == `AMV_A_CTRL);
    wire       slotHit = (paddr[11:6] == `AMV_SLOT_PG);
    wire       scrHit = (paddr[11:5] == `AMV_SCR_PG);
    wire       ramHit = (paddr[11:7] == `AMV_RAM_PG);
    wire       ramWr  = wrDone & ramHit & ~busy;
    wire       clr    = (cst_r == C_CLR);
    wire       wdHit  = awake & (wdCnt_r == WDOG_CYCLES - 25'h0000001);
    wire       goSleep = wdHit | (ctlWr & pwdata[`AMV_C_SLEEP] & (pwr_r != P_SLEEP));
    wire       goIdle = ctlWr & pwdata[`AMV_C_IDLE] & awake & ~goSleep;
    wire       goWake = ctlWr & pwdata[`AMV_C_WAKE] & ~awake & ~clr;
    wire       goExec = ctlWr & pwdata[`AMV_C_EXEC] & awake & ~busy;
    wire [3:0] keySel = addr_r[3:0];
    wire [3:0] tgt    = keySel[0] ? keySel : keySel + 4'h1;
    wire [15:0] tgtCfg = scfgV[{tgt, 4'h0} +: 16];
    wire [3:0] cPrev  = cIdx_r - 4'h1;
    wire [31:0] digW  = dig_r[{3'h7 - cPrev[2:0], 5'h00} +: 32];
    wire       lastMiss = miss_r | (ramQ != digW);
    wire [63:0] otpV  = p1[`AMV_M_OTP] ? {otp0_r, otp1_r} : 64'h0;
    wire [103:0] exV  = {ex0_r, ex1_r, ex2_r, ex3_r};
    // Fixed tail of the message after the two 32-byte blocks
    wire [191:0] tail = {exV[103:72], otpV, exV[71:48], serial_r[23:16],
                         exV[47:16], serial_r[7:0], serial_r[15:8], exV[15:0]};
    wire [4:0] tIdx   = pW_r - `AMV_W_TAIL;
    wire [31:0] tailW = tail[{3'h5 - tIdx[2:0], 5'h00} +: 32];

    ////////////////////////////////////////////////////////////////////////////////
    // Slot configuration words, one per slot
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : gSlot
            reg [15:0] q;
            always @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    q <= 16'h0000;
                end else if (wrDone & slotHit & (paddr[5:2] == g)) begin
                    q <= pwdata[15:0];
                end
            end
            assign scfgV[g*16 +: 16] = q;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Operand buffer; the sleep sweep owns the write port while it runs
    always @* begin
        case (cst_r)
            C_STRM:  ramRd = (wIdx_r < `AMV_W_CHAL) ? `AMV_R_KEY + wIdx_r
                                                    : `AMV_R_CHAL + (wIdx_r - `AMV_W_CHAL);
            C_CMP:   ramRd = `AMV_R_RESP + {1'b0, cIdx_r};
            C_COPY:  ramRd = `AMV_R_TGT + {1'b0, cIdx_r};
            default: ramRd = paddr[6:2];
        endcase
    end

    amv_ram uRam (
        .core_clk (core_clk),
        .wrEn     (clr | ramWr),
        .wrAddr   (clr ? clrIdx_r : paddr[6:2]),
        .wrData   (clr ? 32'h00000000 : pwdata),
        .rdAddr   (ramRd),
        .rdData   (ramQ)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Read/write access parameter check
    wire       isWr  = (opc == `AMV_OP_WRITE);
    wire [6:0] cByte = {addr_r[4:3], addr_r[2:0], 2'b00};
    wire [15:0] dCfg = scfgV[{addr_r[6:3], 4'h0} +: 16];
    wire       dSec  = dCfg[`AMV_SC_SECRET];
    wire       dEnc  = dCfg[`AMV_SC_ENCRD];
    wire [1:0] oMode = cfg_r[5:4];

    always @* begin
        accCode = `AMV_ST_OK;
        accBlk  = 4'h0;
        if ((p1[6:2] != 5'h00) || (p1[1:0] == 2'h3) || (addr_r[15:8] != 8'h00)) begin
            accCode = `AMV_ST_PARSE;
        end else begin
            case (p1[1:0])
                `AMV_Z_CFG: begin
                    accBlk = {2'b00, addr_r[4:3]};
                    if ((addr_r[7:5] != 3'h0) || (addr_r[4:3] == 2'h3)) begin
                        accCode = `AMV_ST_PARSE;
                    end else if ((cByte > `AMV_CFG_MAX) || (isWr && cByte < `AMV_CFG_WMIN)) begin
                        accCode = `AMV_ST_PARSE;
                    end else if (isWr && cfg_r[`AMV_F_CFGLK]) begin
                        accCode = `AMV_ST_EXEC;
                    end
                end
                `AMV_Z_OTP: begin
                    accBlk = {3'b000, addr_r[3]};
                    if (addr_r[7:4] != 4'h0) begin
                        accCode = `AMV_ST_PARSE;
                    end else if (!isWr && (!cfg_r[`AMV_F_OTPLK] || oMode == `AMV_OTP_LEG)) begin
                        accCode = `AMV_ST_EXEC;
                    end else if (isWr && cfg_r[`AMV_F_OTPLK] && oMode != `AMV_OTP_CONS) begin
                        accCode = `AMV_ST_EXEC;
                    end
                end
                `AMV_Z_DATA: begin
                    accBlk = addr_r[6:3];
                    if (addr_r[7]) begin
                        accCode = `AMV_ST_PARSE;
                    end else if (!p1[`AMV_Z_SIZE] && dSec) begin
                        accCode = `AMV_ST_EXEC;
                    end else if (!isWr && (!cfg_r[`AMV_F_DATLK] || (dSec && !dEnc))) begin
                        accCode = `AMV_ST_EXEC;
                    end else if (isWr && cfg_r[`AMV_F_DATLK] && dCfg[15:12] != 4'h0) begin
                        accCode = `AMV_ST_EXEC;
                    end
                end
                default: accCode = `AMV_ST_PARSE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Software-held operand and configuration registers
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cmd_r    <= 16'h0000;
            addr_r   <= 16'h0000;
            cfg_r    <= 6'h00;
            serial_r <= 24'h000000;
            otp0_r   <= 32'h00000000;
            otp1_r   <= 32'h00000000;
            ex0_r    <= 32'h00000000;
            ex1_r    <= 32'h00000000;
            ex2_r    <= 32'h00000000;
            ex3_r    <= 8'h00;
        end else if (wrDone && !busy) begin
            case (paddr)
                `AMV_A_CMD:    cmd_r    <= pwdata[15:0];
                `AMV_A_ADDR:   addr_r   <= pwdata[15:0];
                `AMV_A_CFG:    cfg_r    <= pwdata[5:0];
                `AMV_A_SERIAL: serial_r <= pwdata[23:0];
                `AMV_A_OTP0:   otp0_r   <= pwdata;
                `AMV_A_OTP1:   otp1_r   <= pwdata;
                `AMV_A_EX0:    ex0_r    <= pwdata;
                `AMV_A_EX1:    ex1_r    <= pwdata;
                `AMV_A_EX2:    ex2_r    <= pwdata;
                `AMV_A_EX3:    ex3_r    <= pwdata[31:24];
                default:       cmd_r    <= cmd_r;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power states, watchdog and command engine
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pwr_r <= P_SLEEP;
            cst_r <= C_IDLE;
            wdCnt_r <= 25'h0000000;
            wIdx_r <= 5'h00;
            pW_r <= 5'h00;
            pSel_r <= S_RAM;
            pV_r <= 1'b0;
            cIdx_r <= 4'h0;
            clrIdx_r <= 5'h00;
            miss_r <= 1'b0;
            dig_r <= 256'h0;
            stat_r <= `AMV_ST_OK;
            copied_r <= 1'b0;
            nflag_r <= 1'b0;
            shaWord_r <= 32'h00000000;
            shaValid_r <= 1'b0;
            shaLast_r <= 1'b0;
            for (i = 0; i < 8; i = i + 1) begin
                scr_r[i] <= 32'h00000000;
            end
        end else if (goSleep) begin
            // Aborts any command in flight and wipes volatile state
            pwr_r <= P_SLEEP;
            cst_r <= C_CLR;
            clrIdx_r <= 5'h00;
            pV_r <= 1'b0;
            shaValid_r <= 1'b0;
            shaLast_r <= 1'b0;
            stat_r <= `AMV_ST_OK;
            copied_r <= 1'b0;
            nflag_r <= 1'b0;
            dig_r <= 256'h0;
            for (i = 0; i < 8; i = i + 1) begin
                scr_r[i] <= 32'h00000000;
            end
        end else begin
            if (goWake) begin
                pwr_r <= P_AWAKE;
                wdCnt_r <= 25'h0000000;
                stat_r <= `AMV_ST_WAKE;
            end else if (awake) begin
                wdCnt_r <= wdCnt_r + 25'h0000001;
            end
            // Second stage of the message stream; RAM data lands here
            shaValid_r <= pV_r;
            shaLast_r <= pV_r & (pW_r == `AMV_MSG_LAST);
            case (pSel_r)
                S_SCR:   shaWord_r <= scr_r[pW_r[2:0]];
                S_TAIL:  shaWord_r <= tailW;
                default: shaWord_r <= ramQ;
            endcase
            pV_r <= 1'b0;
            case (cst_r)
                C_IDLE: begin
                    if (wrDone && scrHit) begin
                        scr_r[paddr[4:2]] <= pwdata;
                    end
                    if (wrDone && paddr == `AMV_A_NFLAG) begin
                        nflag_r <= pwdata[0];
                    end
                    if (goExec) begin
                        if (opc == `AMV_OP_READ || opc == `AMV_OP_WRITE) begin
                            stat_r <= accCode;
                        end else if (opc != `AMV_OP_VERIFY) begin
                            stat_r <= `AMV_ST_PARSE;
                        end else if ((p1 & `AMV_M_RSVD) != 8'h00) begin
                            stat_r <= `AMV_ST_PARSE;
                        end else if ((p1[`AMV_M_CHAL] | p1[`AMV_M_KEY])
                                     && (p1[`AMV_M_SRC] != nflag_r)) begin
                            stat_r <= `AMV_ST_EXEC;
                        end else begin
                            cst_r <= C_STRM;
                            wIdx_r <= 5'h00;
                        end
                    end
                end
                C_STRM: begin
                    pV_r <= 1'b1;
                    pW_r <= wIdx_r;
                    if (wIdx_r < `AMV_W_CHAL) begin
                        pSel_r <= p1[`AMV_M_KEY] ? S_SCR : S_RAM;
                    end else if (wIdx_r < `AMV_W_TAIL) begin
                        pSel_r <= p1[`AMV_M_CHAL] ? S_SCR : S_RAM;
                    end else begin
                        pSel_r <= S_TAIL;
                    end
                    wIdx_r <= wIdx_r + 5'h01;
                    if (wIdx_r == `AMV_MSG_LAST) begin
                        cst_r <= C_WDIG;
                    end
                end
                C_WDIG: begin
                    if (shaDone) begin
                        dig_r <= shaDigest;
                        cst_r <= C_CMP;
                        cIdx_r <= 4'h0;
                        miss_r <= 1'b0;
                    end
                end
                C_CMP: begin
                    cIdx_r <= cIdx_r + 4'h1;
                    if (cIdx_r != 4'h0 && ramQ != digW) begin
                        miss_r <= 1'b1;
                    end
                    if (cIdx_r == `AMV_CMP_END) begin
                        stat_r <= lastMiss ? `AMV_ST_MISS : `AMV_ST_OK;
                        cIdx_r <= 4'h0;
                        if (!lastMiss && p1 == `AMV_M_COPY && tgtCfg[3:0] == 4'h0) begin
                            cst_r <= C_COPY;
                        end else begin
                            cst_r <= C_IDLE;
                        end
                    end
                end
                C_COPY: begin
                    cIdx_r <= cIdx_r + 4'h1;
                    if (cIdx_r != 4'h0) begin
                        scr_r[cPrev[2:0]] <= ramQ;
                    end
                    if (cIdx_r == `AMV_CMP_END) begin
                        copied_r <= 1'b1;
                        cst_r <= C_IDLE;
                    end
                end
                C_CLR: begin
                    clrIdx_r <= clrIdx_r + 5'h01;
                    if (clrIdx_r == 5'h1F) begin
                        cst_r <= C_IDLE;
                    end
                end
                default: cst_r <= C_IDLE;
            endcase
            if (goIdle) begin
                // Idle keeps the scratch digest unless it came from a slot copy
                pwr_r <= P_IDLE;
                cst_r <= C_IDLE;
                // A copy still running when idle arrives must not survive either
                if (copied_r || cst_r == C_COPY) begin
                    copied_r <= 1'b0;
                    for (i = 0; i < 8; i = i + 1) begin
                        scr_r[i] <= 32'h00000000;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB read mux and response; one wait state so RAM reads can settle
    always @* begin
        rdMux = 32'h00000000;
        rdErr = 1'b0;
        if (slotHit) begin
            rdMux = {16'h0000, scfgV[{paddr[5:2], 4'h0} +: 16]};
        end else if (scrHit) begin
            rdErr = 1'b1; // Scratch digest is never readable
        end else if (ramHit) begin
            rdMux = ramQ;
            rdErr = busy;
        end else begin
            case (paddr)
                `AMV_A_CTRL:   rdMux = 32'h00000000;
                `AMV_A_CMD:    rdMux = {16'h0000, cmd_r};
                `AMV_A_ADDR:   rdMux = {16'h0000, addr_r};
                `AMV_A_CFG:    rdMux = {26'h0000000, cfg_r};
                `AMV_A_STAT:   rdMux = {21'h000000, pwr_r == P_IDLE, awake, busy, stat_r};
                `AMV_A_ACC:    rdMux = {25'h0000000, accBlk, addr_r[2:0]};
                `AMV_A_NFLAG:  rdMux = {31'h00000000, nflag_r};
                `AMV_A_SERIAL: rdMux = {8'h00, serial_r};
                `AMV_A_OTP0:   rdMux = otp0_r;
                `AMV_A_OTP1:   rdMux = otp1_r;
                `AMV_A_EX0:    rdMux = ex0_r;
                `AMV_A_EX1:    rdMux = ex1_r;
                `AMV_A_EX2:    rdMux = ex2_r;
                `AMV_A_EX3:    rdMux = {ex3_r, 24'h000000};
                default:       rdErr = 1'b1;
            endcase
        end
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h00000000 : rdMux;
            pslverr <= rdErr & ~(pwrite & scrHit);
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule // amv_core
`default_nettype wire

// *** shared/amv_map.vh ***
// Purpose: Constants for the memory-access checker and MAC-verify block
// Assumes: 32-bit APB data, one word per register
// Notes:   Definitions only
`ifndef AMV_MAP_VH
`define AMV_MAP_VH

// APB register byte offsets
`define AMV_A_CTRL    12'h000
`define AMV_A_CMD     12'h004
`define AMV_A_ADDR    12'h008
`define AMV_A_CFG     12'h00C
`define AMV_A_STAT    12'h010
`define AMV_A_ACC     12'h014
`define AMV_A_NFLAG   12'h018
`define AMV_A_SERIAL  12'h01C
`define AMV_A_OTP0    12'h020
`define AMV_A_OTP1    12'h024
`define AMV_A_EX0     12'h028
`define AMV_A_EX1     12'h02C
`define AMV_A_EX2     12'h030
`define AMV_A_EX3     12'h034
`define AMV_SLOT_PG   6'h01
`define AMV_SCR_PG    7'h04
`define AMV_RAM_PG    5'h02

// Control register pulse bits
`define AMV_C_WAKE    0
`define AMV_C_SLEEP   1
`define AMV_C_IDLE    2
`define AMV_C_EXEC    3

// Lock and usage-mode fields of the configuration register
`define AMV_F_CFGLK   0
`define AMV_F_OTPLK   1
`define AMV_F_DATLK   2
`define AMV_OTP_RO    2'h0
`define AMV_OTP_CONS  2'h1
`define AMV_OTP_LEG   2'h2

// Slot configuration word fields
`define AMV_SC_SECRET 7
`define AMV_SC_ENCRD  6

// Status codes
`define AMV_ST_OK     8'h00
`define AMV_ST_MISS   8'h01
`define AMV_ST_PARSE  8'h03
`define AMV_ST_EXEC   8'h0F
`define AMV_ST_WAKE   8'h11

// Opcodes and zones
`define AMV_OP_READ   8'h02
`define AMV_OP_WRITE  8'h12
`define AMV_OP_VERIFY 8'h28
`define AMV_Z_CFG     2'h0
`define AMV_Z_OTP     2'h1
`define AMV_Z_DATA    2'h2
`define AMV_Z_SIZE    7
`define AMV_CFG_WMIN  7'h10
`define AMV_CFG_MAX   7'h57

// Verify mode bits
`define AMV_M_CHAL    0
`define AMV_M_KEY     1
`define AMV_M_SRC     2
`define AMV_M_OTP     5
`define AMV_M_RSVD    8'hD8
`define AMV_M_COPY    8'h01

// Message and buffer layout, in words
`define AMV_MSG_LAST  5'h15
`define AMV_W_CHAL    5'h08
`define AMV_W_TAIL    5'h10
`define AMV_R_CHAL    5'h00
`define AMV_R_RESP    5'h08
`define AMV_R_KEY     5'h10
`define AMV_R_TGT     5'h18
`define AMV_CMP_END   4'h8

// Watchdog
`define AMV_WDOG_MS   1000
`define AMV_CLK_KHZ   20000

`endif

// *** hw/amv_ram.v ***
// Purpose: Operand buffer, 32 words, one write and one registered read port
// Assumes: Single clock
// Notes:   Contents are not reset; the core sweeps it clear on sleep
`timescale 1ns/1ps
`default_nettype none
module amv_ram (
    // Clock
    input  wire        core_clk,
    // Write port
    input  wire        wrEn,
    input  wire [4:0]  wrAddr,
    input  wire [31:0] wrData,
    // Read port
    input  wire [4:0]  rdAddr,
    output reg  [31:0] rdData
);
    reg [31:0] mem [0:31];

    always @(posedge core_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule // amv_ram
`default_nettype wire

// *** tb/amv_core_assertions.sv ***
// Purpose: Port-level checks for amv_core
// Assumes: One APB wait state, 22-word hash stream
// Notes:   Bound from the testbench file
`timescale 1ns/1ps
`default_nettype none
module amv_core_assertions (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Hash stream
    input wire logic        shaValid_r,
    input wire logic        shaLast_r
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_ready_single: assert property (pready |=> !pready) else $error("pready long");
    a_one_wait: assert property (psel && penable && !pready |=> pready) else $error("no ack");
    a_ready_qual: assert property (pready |-> psel && penable) else $error("stray ack");
    a_err_qual: assert property (pslverr |-> pready) else $error("stray err");
    a_write_zero: assert property (pready && pwrite |-> prdata == 32'h0) else $error("wr data");
    a_stream_len: assert property ($rose(shaValid_r) |-> ##21 shaLast_r) else $error("len");
    a_last_valid: assert property (shaLast_r |-> shaValid_r) else $error("last alone");
    a_stream_gap: assert property (shaValid_r && !shaLast_r |=> shaValid_r) else $error("gap");
    a_last_end: assert property (shaLast_r |=> !shaValid_r) else $error("overrun");
    c_err: cover property (pslverr);
    c_stream: cover property (shaLast_r);
    c_read: cover property (pready && !pwrite);
endmodule // amv_core_assertions
`default_nettype wire

// *** tb/amv_sha_model.sv ***
// Purpose: Hash engine stand-in
// Assumes: One word per shaValid_r pulse
// Notes:   Answers only a full stream; digest lines carry junk otherwise
`timescale 1ns/1ps
`default_nettype none
module amv_sha_model #(parameter logic [255:0] DIG = 256'h0) (
    // Clock
    input  wire logic         core_clk,
    // Stream
    input  wire logic         shaValid_r,
    input  wire logic         shaLast_r,
    input  wire logic [31:0]  shaWord_r,
    output var  logic [255:0] shaDigest = ~DIG,
    output var  logic         shaDone = 1'h0
);
    logic [5:0] cnt_r = 6'h00;
    logic [31:0] lastW = 32'h0;
    always @(posedge core_clk) begin
        shaDone <= 1'h0;
        shaDigest <= ~DIG;
        if (shaValid_r)
            cnt_r <= cnt_r + 6'h01;
        if (shaLast_r)
            lastW <= shaWord_r;
        if (shaLast_r && cnt_r == 6'h15) begin
            shaDone <= 1'h1;
            shaDigest <= DIG;
            cnt_r <= 6'h00;
        end
    end
endmodule // amv_sha_model
`default_nettype wire

// *** tb/amv_testbench.sv ***
// Purpose: Self-checking bench for amv_core
// Assumes: Short watchdog, APB master tasks
// Notes:   Hash engine is a model
`include "amv_map.vh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [255:0] DIG = {4{64'h0123456789ABCDEF}};
    logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, er;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, shaWord_r;
    logic pready, pslverr, shaValid_r, shaLast_r, shaDone;
    logic [255:0] shaDigest;
    int fail_count = 0, cmp_count = 0;
    always #25 core_clk = ~core_clk;
    amv_core #(.WDOG_CYCLES(25'h258)) dut_u (.core_clk, .rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .shaWord_r, .shaValid_r, .shaLast_r,
        .shaDigest, .shaDone);
    amv_sha_model #(.DIG(DIG)) sha_u (.core_clk, .shaValid_r, .shaLast_r, .shaWord_r,
        .shaDigest, .shaDone);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Request held until the edge that samples pready high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, wr, a, d};
        @(posedge core_clk);
        penable <= 1'h1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        if (n >= 50) begin
            fail_count++;
            $display("unexpected at %0t: no pready", $time);
            print_verdict();
        end else begin
            rd = prdata;
            er = pslverr;
            {psel, penable} <= 2'h0;
        end
    endtask
    // Busy bit is part of the compare, so a hung command fails too
    task automatic run_cmd(input logic [31:0] c, a, input logic [7:0] exp);
        int n = 0;
        apb(1, `AMV_A_CMD, c);
        apb(1, `AMV_A_ADDR, a);
        apb(1, `AMV_A_CTRL, 32'h8);
        do begin
            apb(0, `AMV_A_STAT, 0);
            n++;
        end while (rd[8] !== 1'h0 && n < 60);
        check({23'h0, rd[8:0]}, {24'h0, exp});
    endtask
    task automatic wake_chk();
        apb(1, `AMV_A_CTRL, 32'h1);
        apb(0, `AMV_A_STAT, 0);
        check(rd[10:0], 11'h211);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_addr();
        wake_chk();
        run_cmd(32'h0012, 32'h2, 8'h03);
        run_cmd(32'h0002, 32'h0, 8'h00);
        run_cmd(32'h0002, 32'h18, 8'h03);
        run_cmd(32'h0002, 32'h20, 8'h03);
        run_cmd(32'h0302, 32'h0, 8'h03);
        run_cmd(32'h0202, 32'h100, 8'h03);
        run_cmd(32'h0202, 32'h0, 8'h0F);
        run_cmd(32'h0102, 32'h0, 8'h0F);
        run_cmd(32'h0112, 32'h8, 8'h00);
        run_cmd(32'h0112, 32'h10, 8'h03);
        run_cmd(32'h8212, 32'h78, 8'h00);
        $display("done addr");
    endtask
    task automatic t_verify();
        apb(1, `AMV_A_CTRL, 32'h4);
        wake_chk();
        for (int w = 0; w < 8; w++)
            apb(1, 12'h120 + 12'(4 * w), DIG[255 - 32 * w -: 32]);
        // Last message word is serial bytes 0 and 1, then extra bytes 11 and 12
        apb(1, `AMV_A_SERIAL, 32'h00C3B2A1);
        apb(1, `AMV_A_EX2, 32'h000000D4);
        apb(1, `AMV_A_EX3, 32'hE5000000);
        run_cmd(32'h0028, 32'hF2, 8'h00);
        check(sha_u.lastW, 32'hA1B2D4E5);
        apb(1, 12'h120, ~DIG[255:224]);
        run_cmd(32'h0028, 32'h2, 8'h01);
        run_cmd(32'h0828, 32'h2, 8'h03);
        run_cmd(32'h0528, 32'h2, 8'h0F);
        $display("done verify");
    endtask
    task automatic t_wdog();
        apb(0, 12'hFFC, 0);
        check({31'h0, er}, 32'h1);
        // Still awake from the verify test, so idle first or the wake is ignored
        apb(1, `AMV_A_CTRL, 32'h4);
        wake_chk();
        repeat (700) @(posedge core_clk);
        apb(0, `AMV_A_STAT, 0);
        check(rd[10:0], 11'h000);
        $display("done watchdog");
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'h0;
        t_addr();
        t_verify();
        t_wdog();
        print_verdict();
    end
endmodule // testbench
bind amv_core amv_core_assertions chk_u (.core_clk, .rst, .psel, .penable, .pwrite, .prdata,
    .pready, .pslverr, .shaValid_r, .shaLast_r);
`default_nettype wire
